// ===== design/drtc_consts.svh
// Constants for the DRAM row type configuration block.
// Assumes inclusion by bare name from the design directory.
`ifndef DRTC_CONSTS_SVH
`define DRTC_CONSTS_SVH
`define DRTC_IDX_UPPER   10'h067
`define DRTC_IDX_LOWER   10'h068
`define DRTC_UP_WMASK    8'hB7
`define DRTC_UPPER_RST   8'h00
`define DRTC_LOWER_RST   8'h00
`define DRTC_HFD_BIT     7
`define DRTC_SEL_BIT     2
`define DRTC_HI_OFS      4
`define DRTC_ROW4        4
`define DRTC_NUM_ROWS    6
`define DRTC_TYPE_SPM    2'h0
`define DRTC_TYPE_EDO    2'h1
`define DRTC_TYPE_SDRAM  2'h2
`define DRTC_TYPE_RSVD   2'h3
`endif

// ===== design/drtc_pkg.sv
// Types for the DRAM row type configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package drtc_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } drtc_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } drtc_apb_rsp_t;
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
   } drtc_acc_req_t;
   typedef struct packed {
      logic       valid;
      logic       hit;
      logic [2:0] row;
      logic [1:0] mem_type;
   } drtc_acc_rsp_t;
   typedef logic [5:0][6:0] drtc_bounds_t;
   typedef struct packed {
      logic          sync1;
      logic          sync2;
      logic          strap_pend;
      logic [7:0]    upper;
      logic [7:0]    lower;
      drtc_apb_rsp_t apb;
      drtc_acc_rsp_t acc;
      logic          pin_a;
      logic          pin_b;
   } drtc_state_t;
endpackage : drtc_pkg

// ===== design/drtc_top.sv
// DRAM row type configuration registers with APB access and row type lookup.
// Assumes one 10 MHz clock, APB master on it, boundaries from same domain.
//
// Notes on behaviour
// - Upper register bit 7 is host frequency: 1 means 66 MHz, 0 means 60 MHz.
// - At reset release host frequency loads inverse of the strap address line.
// - Software write to host frequency overrides the strap until next reset.
// - Upper register holds row 5 code in bits 5,1 and row 4 in 4,0.
// - Lower register holds rows 3..0 codes in bits 7,3 6,2 5,1 4,0.
// - Codes: 00 standard page, 01 extended data out, 10 synchronous, 11 reserved.
// - Cycle timing is chosen from the type code of the targeted row.
// - Copy select set drives duplicate address bits 0 and 1 on enable pins.
// - Copy select clear keeps clock enable function; it resets to zero.
// - Looked-up row is the one whose boundary range holds the address.
//
// Local design decision: the APB register port.
`include "drtc_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module drtc_top
   import drtc_pkg::*;
(
   input  wire logic          i_clock,
   input  wire logic          i_reset,
   input  wire drtc_apb_req_t i_apb,
   output var  drtc_apb_rsp_t o_apb,
   input  wire logic          i_host_addr_strap_line,
   input  wire drtc_bounds_t  i_row_bound,
   input  wire drtc_acc_req_t i_acc,
   output var  drtc_acc_rsp_t o_acc,
   input  wire logic          i_sdram_clk_enable_a,
   input  wire logic          i_sdram_clk_enable_b,
   input  wire logic          i_mem_addr_bit0,
   input  wire logic          i_mem_addr_bit1,
   output var  logic          o_sdram_clk_enable_a,
   output var  logic          o_sdram_clk_enable_b
);

   drtc_state_t st;
   drtc_state_t next_st;

   logic       setup_phase;
   logic       access_phase;
   logic       hit_upper;
   logic       hit_lower;
   logic [1:0] codes [`DRTC_NUM_ROWS];

   assign setup_phase  = i_apb.psel && !i_apb.penable;
   assign access_phase = i_apb.psel && i_apb.penable && st.apb.pready;
   assign hit_upper    = (i_apb.paddr[11:2] == `DRTC_IDX_UPPER) && (i_apb.paddr[1:0] == 2'h0);
   assign hit_lower    = (i_apb.paddr[11:2] == `DRTC_IDX_LOWER) && (i_apb.paddr[1:0] == 2'h0);

   // Per-row type codes
   always_comb begin
      for (int r = 0; r < `DRTC_ROW4; r++) begin
         codes[r] = {st.lower[`DRTC_HI_OFS + r], st.lower[r]};
      end
      for (int r = `DRTC_ROW4; r < `DRTC_NUM_ROWS; r++) begin
         codes[r] = {st.upper[r], st.upper[r - `DRTC_ROW4]};
      end
   end

   always_comb begin
      next_st       = st;
      next_st.sync1 = i_host_addr_strap_line;
      next_st.sync2 = st.sync1;
      // Bus answer: one-cycle access phase
      next_st.apb.pready  = setup_phase;
      next_st.apb.pslverr = setup_phase && !hit_upper && !hit_lower;
      next_st.apb.prdata  = 32'h0000_0000;
      if (setup_phase && !i_apb.pwrite) begin
         if (hit_upper) begin
            next_st.apb.prdata = {24'h00_0000, st.upper};
         end else if (hit_lower) begin
            next_st.apb.prdata = {24'h00_0000, st.lower};
         end
      end
      // Strap capture on release
      if (st.strap_pend) begin
         next_st.upper[`DRTC_HFD_BIT] = !st.sync2;
         next_st.strap_pend           = 1'b0;
      end
      if (access_phase && i_apb.pwrite) begin
         if (hit_upper) begin
            next_st.upper = i_apb.pwdata[7:0] & `DRTC_UP_WMASK;
         end
         if (hit_lower) begin
            next_st.lower = i_apb.pwdata[7:0];
         end
      end
      // Row lookup by boundary, lowest row wins
      next_st.acc.valid    = i_acc.valid;
      next_st.acc.hit      = 1'b0;
      next_st.acc.row      = 3'h0;
      next_st.acc.mem_type = `DRTC_TYPE_SPM;
      for (int r = `DRTC_NUM_ROWS - 1; r >= 0; r--) begin
         if (i_acc.addr < i_row_bound[r]) begin
            next_st.acc.hit      = 1'b1;
            next_st.acc.row      = 3'(r);
            next_st.acc.mem_type = codes[r];
         end
      end
      if (!i_acc.valid) begin
         next_st.acc = st.acc;
         next_st.acc.valid = 1'b0;
      end
      // Enable pins or duplicate address lines
      if (st.upper[`DRTC_SEL_BIT]) begin
         next_st.pin_a = i_mem_addr_bit0;
         next_st.pin_b = i_mem_addr_bit1;
      end else begin
         next_st.pin_a = i_sdram_clk_enable_a;
         next_st.pin_b = i_sdram_clk_enable_b;
      end
      if (i_reset) begin
         next_st.strap_pend = 1'b1;
         next_st.upper      = `DRTC_UPPER_RST;
         next_st.lower      = `DRTC_LOWER_RST;
         next_st.apb        = '0;
         next_st.acc        = '0;
         next_st.pin_a      = 1'b0;
         next_st.pin_b      = 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      st <= next_st;
   end

   assign o_apb                = st.apb;
   assign o_acc                = st.acc;
   assign o_sdram_clk_enable_a = st.pin_a;
   assign o_sdram_clk_enable_b = st.pin_b;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);

   chk_hfd_strap_load: assert property (
      st.strap_pend |=> st.upper[`DRTC_HFD_BIT] == !$past(st.sync2) && !st.strap_pend)
      else $error("Host frequency not loaded from inverted strap");

   chk_reserved_zero: assert property (
      st.upper[6] == 1'b0 && st.upper[3] == 1'b0)
      else $error("Reserved upper bits not zero");

   chk_upper_write: assert property (
      access_phase && i_apb.pwrite && hit_upper
      |=> st.upper == ($past(i_apb.pwdata[7:0]) & `DRTC_UP_WMASK))
      else $error("Upper register write lost");

   chk_lower_write: assert property (
      access_phase && i_apb.pwrite && hit_lower |=> st.lower == $past(i_apb.pwdata[7:0]))
      else $error("Lower register write lost");

   chk_copy_pins: assert property (
      st.upper[`DRTC_SEL_BIT] |=> o_sdram_clk_enable_a == $past(i_mem_addr_bit0)
      && o_sdram_clk_enable_b == $past(i_mem_addr_bit1))
      else $error("Duplicate address not on enable pins");

   chk_normal_pins: assert property (
      !st.upper[`DRTC_SEL_BIT] && !$past(i_reset) |=> o_sdram_clk_enable_b == $past(i_sdram_clk_enable_b))
      else $error("Enable pin function not kept");

   chk_normal_pin_a: assert property (
      !st.upper[`DRTC_SEL_BIT] && !$past(i_reset)
      |=> o_sdram_clk_enable_a == $past(i_sdram_clk_enable_a))
      else $error("First enable pin function not kept");

   chk_select_reset: assert property (
      $past(i_reset)
      |-> st.upper[`DRTC_SEL_BIT] == 1'b0)
      else $error("Copy select not cleared by reset");

   chk_upper_reset: assert property (
      $past(i_reset)
      |-> st.upper == `DRTC_UPPER_RST)
      else $error("Upper register not at reset value");

   chk_lower_reset: assert property (
      $past(i_reset)
      |-> st.lower == `DRTC_LOWER_RST)
      else $error("Lower register not at reset value");

   chk_lookup_type: assert property (
      i_acc.valid |=> o_acc.valid ##0 (!o_acc.hit || o_acc.mem_type == codes[o_acc.row]))
      else $error("Looked-up type does not match row code");

   chk_row_bound: assert property (
      o_acc.valid && o_acc.hit |-> $past(i_acc.addr) < i_row_bound[o_acc.row])
      else $error("Address outside selected row");

   chk_apb_answer: assert property (
      setup_phase |=> o_apb.pready ##1 !o_apb.pready)
      else $error("Bus answer not one cycle");

   chk_apb_idle: assert property (
      !setup_phase
      |=> !o_apb.pready)
      else $error("Bus answer without setup");

   chk_error_miss: assert property (
      setup_phase && !hit_upper && !hit_lower
      |=> o_apb.pslverr)
      else $error("Unmapped address not flagged");

   chk_error_hit: assert property (
      setup_phase && (hit_upper || hit_lower)
      |=> !o_apb.pslverr)
      else $error("Mapped address flagged as error");

   chk_error_data: assert property (
      o_apb.pslverr
      |-> o_apb.prdata == 32'h0000_0000)
      else $error("Error answer carries data");

   chk_read_upper: assert property (
      setup_phase && !i_apb.pwrite && hit_upper
      |=> o_apb.prdata == {24'h00_0000, $past(st.upper)})
      else $error("Upper register read wrong");

   chk_read_lower: assert property (
      setup_phase && !i_apb.pwrite && hit_lower
      |=> o_apb.prdata == {24'h00_0000, $past(st.lower)})
      else $error("Lower register read wrong");

   chk_read_high_zero: assert property (
      o_apb.pready
      |-> o_apb.prdata[31:8] == 24'h00_0000)
      else $error("Read data upper bytes not zero");

   chk_upper_hold: assert property (
      !(access_phase && i_apb.pwrite && hit_upper) && !st.strap_pend
      |=> $stable(st.upper))
      else $error("Upper register changed without write");

   chk_lower_hold: assert property (
      !(access_phase && i_apb.pwrite && hit_lower)
      |=> $stable(st.lower))
      else $error("Lower register changed without write");

   chk_acc_pulse: assert property (
      !i_acc.valid
      |=> !o_acc.valid)
      else $error("Lookup answer without request");

   chk_acc_hold: assert property (
      !i_acc.valid
      |=> $stable({o_acc.hit, o_acc.row, o_acc.mem_type}))
      else $error("Lookup result not held");

   chk_miss_default: assert property (
      o_acc.valid && !o_acc.hit
      |-> o_acc.row == 3'h0 && o_acc.mem_type == `DRTC_TYPE_SPM)
      else $error("Missed lookup not at defaults");

   chk_miss_beyond: assert property (
      o_acc.valid && !o_acc.hit
      |-> $past(i_acc.addr) >= i_row_bound[`DRTC_NUM_ROWS - 1])
      else $error("Lookup missed inside memory");

   chk_lowest_row: assert property (
      o_acc.valid && o_acc.hit && o_acc.row != 3'h0
      |-> $past(i_acc.addr) >= i_row_bound[o_acc.row - 3'h1])
      else $error("Lookup row not the lowest");

   chk_row_range: assert property (
      o_acc.valid && o_acc.hit
      |-> o_acc.row < 3'(`DRTC_NUM_ROWS))
      else $error("Lookup row out of range");

   cov_upper_write: cover property (access_phase && i_apb.pwrite && hit_upper);
   cov_sdram_hit: cover property (o_acc.valid && o_acc.hit && o_acc.mem_type == `DRTC_TYPE_SDRAM);
   cov_copy_mode: cover property (st.upper[`DRTC_SEL_BIT] ##1 !st.upper[`DRTC_SEL_BIT]);
   cov_edo_hit: cover property (o_acc.valid && o_acc.hit && o_acc.mem_type == `DRTC_TYPE_EDO);
   cov_bus_error: cover property (o_apb.pready && o_apb.pslverr);

endmodule : drtc_top
`default_nettype wire

// ===== sim/tb_dram_row_type_config.sv
// Self-checking bench for the DRAM row type configuration block.
// Assumes drtc_pkg and drtc_top compiled first; APB master is this bench.
`timescale 1ns/100ps
`default_nettype none
module tb_dram_row_type_config;
   import drtc_pkg::*;
   logic          i_clock, i_reset, strap, ena, enb, ma0, ma1, o_a, o_b, e;
   drtc_apb_req_t i_apb;
   drtc_apb_rsp_t o_apb;
   drtc_bounds_t  bnd;
   drtc_acc_req_t i_acc;
   drtc_acc_rsp_t o_acc;
   logic [31:0]   r;
   logic [1:0]    c;
   int            failures, compares, up, lo, row, b[6];
   drtc_top drtc_top_inst (.i_clock(i_clock), .i_reset(i_reset), .i_apb(i_apb),
      .o_apb(o_apb), .i_host_addr_strap_line(strap), .i_row_bound(bnd),
      .i_acc(i_acc), .o_acc(o_acc), .i_sdram_clk_enable_a(ena),
      .i_sdram_clk_enable_b(enb), .i_mem_addr_bit0(ma0), .i_mem_addr_bit1(ma1),
      .o_sdram_clk_enable_a(o_a), .o_sdram_clk_enable_b(o_b));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      compares++;
      if (g !== x) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clock) i_apb <= drtc_apb_req_t'{1'b1, 1'b0, w, a, {24'h00_0000, d}};
      @(posedge i_clock) i_apb.penable <= 1'b1;
      do @(posedge i_clock); while (o_apb.pready !== 1'b1);
      chk("pready", 32'h0000_0001, {31'h0000_0000, o_apb.pready});
      r = o_apb.prdata;
      e = o_apb.pslverr;
      i_apb <= '0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 8'h00);
      chk("prdata", x, r);
      chk("pslverr", {31'h0000_0000, xe}, {31'h0000_0000, e});
   endtask : rd
   task automatic pins(input logic s);
      logic [3:0] p1, p2;
      p1 = 4'h0;
      p2 = 4'h0;
      for (int k = 0; k < 12; k++) begin
         @(posedge i_clock);
         if (k > 1) chk("pins", s ? p2[1:0] : p2[3:2], {o_a, o_b});
         p2 = p1;
         p1 = 4'($urandom);
         {ena, enb, ma0, ma1} <= p1;
      end
   endtask : pins
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      failures++;
      results();
   end
   initial begin
      {i_reset, strap, ena, enb, ma0, ma1} = 6'h20;
      {i_apb, i_acc, bnd} = '0;
      {failures, compares} = 0;
      void'($urandom(22476));
      repeat (16) @(posedge i_clock);
      i_reset <= 1'b0;
      rd(12'h19C, 32'h0000_0080, 1'b0);
      rd(12'h1A0, 32'h0000_0000, 1'b0);
      for (int pass = 0; pass < 4; pass++) begin
         up = pass == 0 ? 32'h0000_00A5 : $urandom;
         lo = pass == 0 ? 32'h0000_00CA : $urandom;
         apb(1'b1, 12'h19C, 8'(up));
         apb(1'b1, 12'h1A0, 8'(lo));
         up &= 32'h0000_00B7;
         lo &= 32'h0000_00FF;
         rd(12'h19C, up, 1'b0);
         rd(12'h1A0, lo, 1'b0);
         b[0] = 1 + $urandom % 8;
         for (int k = 1; k < 6; k++) b[k] = b[k-1] + $urandom % 4;
         for (int k = 0; k < 6; k++) bnd[k] <= 7'(b[k]);
         for (int a = 0; a <= b[5] + 1; a++) begin
            @(posedge i_clock) i_acc <= drtc_acc_req_t'{1'b1, 7'(a)};
            @(posedge i_clock) i_acc <= '0;
            @(posedge i_clock);
            row = 0;
            while (row < 6 && a >= b[row]) row++;
            c = row < 4 ? {lo[row+4], lo[row]} : {up[row], up[row-4]};
            chk("lookup", row < 6 ? {25'h0, 2'b11, 3'(row), c} : 32'h0000_0040,
               {25'h0, o_acc});
         end
         pins(up[2]);
      end
      rd(12'h1A4, 32'h0000_0000, 1'b1);
      rd(12'h19D, 32'h0000_0000, 1'b1);
      apb(1'b1, 12'h1A4, 8'hFF);
      rd(12'h19C, up, 1'b0);
      strap <= 1'b1;
      i_reset <= 1'b1;
      repeat (16) @(posedge i_clock);
      i_reset <= 1'b0;
      rd(12'h19C, 32'h0000_0000, 1'b0);
      rd(12'h1A0, 32'h0000_0000, 1'b0);
      pins(1'b0);
      results();
   end
endmodule : tb_dram_row_type_config
`default_nettype wire
